/* inc/lpm_pkg.sv */
// Purpose: Shared constants and types for the low-power mode controller.
// Assumes: One core clock at 100 MHz.
// Notes: Pad configuration travels as a packed struct per pin.
package lpm_pkg;
	localparam int NUM_GPIO = 12;
	localparam int NUM_DRV_GROUPS = 4;
	localparam int CLK_MHZ = 100;
	localparam int NUM_WAKE_PINS = 7;
	// Bit positions in the synchronised pin vector.
	localparam int PIN_EXT_RST_N = 0;
	localparam int PIN_VBUS = 1;
	localparam int PIN_CTS = 2;
	localparam int PIN_DP = 3;
	localparam int PIN_DM = 4;
	localparam int PIN_SS_RESUME = 5;
	localparam int PIN_VDD_GOOD = 6;
	localparam logic [6:0] PIN_RESET_VAL = 7'h41;
	localparam logic [1:0] PULL_NONE = 2'h0;
	localparam logic [1:0] PULL_UP = 2'h1;
	localparam logic [1:0] PULL_DOWN = 2'h2;
	localparam logic [1:0] DRV_FULL = 2'h0;
	localparam logic [1:0] DRV_THREE_QUARTER = 2'h1;
	localparam logic [1:0] DRV_HALF = 2'h2;
	localparam logic [1:0] DRV_QUARTER = 2'h3;
	typedef enum logic [4:0] {
		ST_NORMAL = 5'h01,
		ST_SUSPEND = 5'h02,
		ST_STANDBY = 5'h04,
		ST_POWERDOWN = 5'h08,
		ST_WAKE = 5'h10
	} lpm_state_e;
	typedef struct packed {
		logic out;
		logic oe;
		logic [1:0] pull;
		logic hold;
	} lpm_pad_cfg_s;
	typedef struct packed {
		logic pll_en;
		logic xcvr_en;
		logic core_pwr_en;
		logic retain;
	} lpm_pwr_ctl_s;
endpackage

/* rtl/lpm_ctrl.sv */
// Purpose: Low-power mode sequencing, wake detection and pad state control.
// Assumes: Request strobes come from logic on clk_i; wake and supply pins are asynchronous.
// Notes: The pad drivers are modelled as output, active-low enable and pull controls.
`timescale 1ns/10ps
module lpm_ctrl #(
	parameter int NGPIO = lpm_pkg::NUM_GPIO,
	parameter int NGRP = lpm_pkg::NUM_DRV_GROUPS
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic standby_req_i,
	input wire logic suspend_req_i,
	input wire logic fw_loaded_i,
	input wire logic cts_wake_pol_i,
	input wire logic ext_reset_n_i,
	input wire logic vbus_i,
	input wire logic cts_i,
	input wire logic dp_i,
	input wire logic dm_i,
	input wire logic ss_resume_i,
	input wire logic vdd_good_i,
	input wire lpm_pkg::lpm_pad_cfg_s pad_cfg_i [NGPIO],
	input wire logic [NGRP-1:0][1:0] drive_cfg_i,
	output logic pll_en_o,
	output logic xcvr_en_o,
	output logic core_pwr_en_o,
	output logic retain_o,
	output logic pc_reset_o,
	output logic fw_reload_o,
	output logic low_power_o,
	output logic [4:0] state_o,
	output logic [NGPIO-1:0] gpio_o,
	output logic [NGPIO-1:0] gpio_oe_n_o,
	output logic [NGPIO-1:0] gpio_pu_o,
	output logic [NGPIO-1:0] gpio_pd_o,
	output logic [NGRP-1:0][1:0] drive_str_o
);
	lpm_pkg::lpm_state_e state_q;
	lpm_pkg::lpm_pwr_ctl_s pwr_q;
	logic [lpm_pkg::NUM_WAKE_PINS-1:0] pin_meta_q;
	logic [lpm_pkg::NUM_WAKE_PINS-1:0] pin_q;
	logic [lpm_pkg::NUM_WAKE_PINS-1:0] pin_prev_q;
	logic pc_reset_q;
	logic fw_reload_q;
	logic [NGPIO-1:0] hold_out_q;
	logic [NGPIO-1:0] hold_oe_q;
	logic wake_ext_rst;
	logic wake_standby;
	logic wake_suspend;
	logic vdd_lost;
	logic vdd_back;
	logic in_low_power;

	////////////////////////////////////////////////////////////////////////////
	// Pins pass two flops; logic examines the second flop, and a third flop's copy for DP and DM edges.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_meta_q <= lpm_pkg::PIN_RESET_VAL;
			pin_q <= lpm_pkg::PIN_RESET_VAL;
			pin_prev_q <= lpm_pkg::PIN_RESET_VAL;
		end else begin
			pin_meta_q <= {vdd_good_i, ss_resume_i, dm_i, dp_i, cts_i, vbus_i, ext_reset_n_i};
			pin_q <= pin_meta_q;
			pin_prev_q <= pin_q;
		end
	end

	assign wake_ext_rst = ~pin_q[lpm_pkg::PIN_EXT_RST_N];
	assign wake_standby = pin_q[lpm_pkg::PIN_VBUS] | (pin_q[lpm_pkg::PIN_CTS] == cts_wake_pol_i) | wake_ext_rst;
	assign wake_suspend = wake_standby | pin_q[lpm_pkg::PIN_SS_RESUME]
		| (pin_q[lpm_pkg::PIN_DP] ^ pin_prev_q[lpm_pkg::PIN_DP])
		| (pin_q[lpm_pkg::PIN_DM] ^ pin_prev_q[lpm_pkg::PIN_DM]);
	assign vdd_lost = ~pin_q[lpm_pkg::PIN_VDD_GOOD];
	assign vdd_back = pin_q[lpm_pkg::PIN_VDD_GOOD];
	assign in_low_power = (state_q != lpm_pkg::ST_NORMAL) && (state_q != lpm_pkg::ST_WAKE);

	////////////////////////////////////////////////////////////////////////////
	// Mode sequencer. Supply loss outranks every other event.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= lpm_pkg::ST_NORMAL;
		end else if (vdd_lost) begin
			state_q <= lpm_pkg::ST_POWERDOWN;
		end else begin
			case (state_q)
				lpm_pkg::ST_NORMAL: begin
					if (standby_req_i) begin
						state_q <= lpm_pkg::ST_STANDBY;
					end else if (suspend_req_i) begin
						state_q <= lpm_pkg::ST_SUSPEND;
					end
				end
				lpm_pkg::ST_SUSPEND: begin
					if (wake_suspend) begin
						state_q <= lpm_pkg::ST_NORMAL;
					end
				end
				lpm_pkg::ST_STANDBY: begin
					if (wake_standby) begin
						state_q <= lpm_pkg::ST_WAKE;
					end
				end
				lpm_pkg::ST_POWERDOWN: begin
					if (vdd_back | wake_ext_rst) begin
						state_q <= lpm_pkg::ST_WAKE;
					end
				end
				lpm_pkg::ST_WAKE: begin
					state_q <= lpm_pkg::ST_NORMAL;
				end
				default: begin
					state_q <= lpm_pkg::ST_NORMAL;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power controls follow the next state so they change with the mode.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pwr_q <= '{pll_en: 1'b1, xcvr_en: 1'b1, core_pwr_en: 1'b1, retain: 1'b0};
		end else if (vdd_lost) begin
			pwr_q <= '{pll_en: 1'b0, xcvr_en: 1'b0, core_pwr_en: 1'b0, retain: 1'b0};
		end else if (state_q == lpm_pkg::ST_NORMAL && standby_req_i) begin
			pwr_q.pll_en <= 1'b0;
			pwr_q.xcvr_en <= 1'b0;
			pwr_q.core_pwr_en <= 1'b0;
			pwr_q.retain <= 1'b1;
		end else if (state_q == lpm_pkg::ST_NORMAL && suspend_req_i) begin
			// The transceiver stays up in suspend so that it can see resume signalling.
			pwr_q.pll_en <= 1'b0;
			pwr_q.retain <= 1'b1;
		end else if ((state_q == lpm_pkg::ST_SUSPEND && wake_suspend) || state_q == lpm_pkg::ST_WAKE) begin
			pwr_q <= '{pll_en: 1'b1, xcvr_en: 1'b1, core_pwr_en: 1'b1, retain: 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Program counter reset and firmware reload flag.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pc_reset_q <= 1'b0;
		end else begin
			// suspend resumes unless woken by reset
			pc_reset_q <= (state_q == lpm_pkg::ST_WAKE)
				|| (state_q == lpm_pkg::ST_SUSPEND && wake_ext_rst && !vdd_lost);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			fw_reload_q <= 1'b0;
		end else if (state_q == lpm_pkg::ST_POWERDOWN) begin
			// state lost, reload required; set wins over clear
			fw_reload_q <= 1'b1;
		end else if (fw_loaded_i) begin
			fw_reload_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad control. Held copies of output and enable are frozen at low-power entry so firmware writes
	// made while the core is unpowered cannot disturb them; pull controls follow pad_cfg_i at all times.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			hold_out_q <= '0;
			hold_oe_q <= '0;
		end else if (!in_low_power) begin
			for (int i = 0; i < NGPIO; i++) begin
				hold_out_q[i] <= pad_cfg_i[i].out;
				hold_oe_q[i] <= pad_cfg_i[i].oe;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			gpio_o <= '0;
			gpio_oe_n_o <= '1;
			gpio_pu_o <= '0;
			gpio_pd_o <= '0;
		end else begin
			for (int i = 0; i < NGPIO; i++) begin
				if (!in_low_power) begin
					gpio_o[i] <= pad_cfg_i[i].out;
					gpio_oe_n_o[i] <= ~pad_cfg_i[i].oe;
				end else if (state_q != lpm_pkg::ST_POWERDOWN || pad_cfg_i[i].hold) begin
					gpio_o[i] <= hold_out_q[i];
					gpio_oe_n_o[i] <= ~hold_oe_q[i];
				end else begin
					gpio_o[i] <= 1'b0;
					gpio_oe_n_o[i] <= 1'b1;
				end
				gpio_pu_o[i] <= (pad_cfg_i[i].pull == lpm_pkg::PULL_UP);
				gpio_pd_o[i] <= (pad_cfg_i[i].pull == lpm_pkg::PULL_DOWN);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			drive_str_o <= {NGRP{lpm_pkg::DRV_FULL}};
		end else begin
			drive_str_o <= drive_cfg_i;
		end
	end

	assign pll_en_o = pwr_q.pll_en;
	assign xcvr_en_o = pwr_q.xcvr_en;
	assign core_pwr_en_o = pwr_q.core_pwr_en;
	assign retain_o = pwr_q.retain;
	assign pc_reset_o = pc_reset_q;
	assign fw_reload_o = fw_reload_q;
	assign state_o = state_q;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			low_power_o <= 1'b0;
		end else begin
			low_power_o <= (state_q != lpm_pkg::ST_NORMAL);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	a_standby_entry: assert property (state_q == lpm_pkg::ST_NORMAL && standby_req_i && !vdd_lost |=> state_q == lpm_pkg::ST_STANDBY) else $error("standby not entered");
	a_standby_restart: assert property (state_q == lpm_pkg::ST_STANDBY && wake_standby && !vdd_lost |=> ##1 pc_reset_o) else $error("no restart after standby");
	a_standby_retain: assert property (state_q == lpm_pkg::ST_STANDBY |-> retain_o) else $error("retention lost in standby");
	a_pll_off: assert property (state_q == lpm_pkg::ST_STANDBY |-> !pll_en_o) else $error("PLL on in standby");
	a_core_off: assert property (state_q == lpm_pkg::ST_STANDBY |-> !xcvr_en_o && !core_pwr_en_o) else $error("core or transceiver on in standby");
	a_suspend_resume: assert property (state_q == lpm_pkg::ST_SUSPEND && wake_suspend && !wake_ext_rst && !vdd_lost |=> !pc_reset_o [*2]) else $error("suspend wake reset the core");
	a_reload_flag: assert property (state_q == lpm_pkg::ST_POWERDOWN |=> fw_reload_o) else $error("reload flag missing");
	a_pad_hold: assert property (state_q == lpm_pkg::ST_STANDBY && $past(state_q == lpm_pkg::ST_STANDBY) |=> $stable(gpio_o) && $stable(gpio_oe_n_o)) else $error("pads moved in standby");
	a_standby_wake_bound: assert property (state_q == lpm_pkg::ST_STANDBY && wake_standby |-> ##[1:2] state_q == lpm_pkg::ST_NORMAL || state_q == lpm_pkg::ST_POWERDOWN) else $error("standby wake stalled");

	c_standby_cycle: cover property (state_q == lpm_pkg::ST_STANDBY ##[1:20] state_q == lpm_pkg::ST_NORMAL);
	c_suspend_cycle: cover property (state_q == lpm_pkg::ST_SUSPEND ##[1:20] state_q == lpm_pkg::ST_NORMAL);
	c_powerdown_cycle: cover property (state_q == lpm_pkg::ST_POWERDOWN ##[1:20] state_q == lpm_pkg::ST_NORMAL);
endmodule

/* sim/lpm_ctrl_tb.sv */
// Purpose: Self-checking bench for the low-power mode controller.
// Assumes: Requests come through the firmware model; wake pins are driven by the bench.
// Notes: Pads freeze in standby and suspend, and in powerdown only where hold is set, so output and enable config changes there must not reach the pins.
`timescale 1ns/10ps
module lpm_ctrl_tb;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic go_sb = 1'b0, go_sp = 1'b0, fw_loaded = 1'b0, pol = 1'b1, vdd = 1'b1;
	logic [5:0] wk = 6'h01;
	logic [7:0] drv = 8'hE4;
	logic sb_req, sp_req, pll, xcvr, core, ret, pcr, fwr, lowp;
	logic [4:0] state;
	logic [11:0] gout, goen, gpu, gpd;
	logic [7:0] dstr;
	lpm_pkg::lpm_pad_cfg_s pad_cfg [12];
	int failures = 0, compares = 0, pcr_n = 0, cyc = 0;

	lpm_fw_model fw (.clk_i(clk_i), .go_sb_i(go_sb), .go_sp_i(go_sp), .standby_req_o(sb_req),
		.suspend_req_o(sp_req));
	lpm_ctrl dut (.clk_i(clk_i), .srst_i(srst_i), .standby_req_i(sb_req), .suspend_req_i(sp_req),
		.fw_loaded_i(fw_loaded), .cts_wake_pol_i(pol), .ext_reset_n_i(wk[0]), .vbus_i(wk[1]),
		.cts_i(wk[2]), .dp_i(wk[3]), .dm_i(wk[4]), .ss_resume_i(wk[5]), .vdd_good_i(vdd),
		.pad_cfg_i(pad_cfg), .drive_cfg_i(drv), .pll_en_o(pll), .xcvr_en_o(xcvr),
		.core_pwr_en_o(core), .retain_o(ret), .pc_reset_o(pcr), .fw_reload_o(fwr),
		.low_power_o(lowp), .state_o(state), .gpio_o(gout), .gpio_oe_n_o(goen),
		.gpio_pu_o(gpu), .gpio_pd_o(gpd), .drive_str_o(dstr));

	////////////////////////////////////////////////////////////////
	initial forever #5 clk_i = ~clk_i;

	task automatic wrap_up();
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// The hang limit is well above the few hundred cycles the scenarios need.
	always @(posedge clk_i) begin
		if (pcr === 1'b1)
			pcr_n++;
		cyc++;
		if (cyc == 5000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic wait_st(input logic [4:0] e);
		for (int i = 0; i < 20 && state !== e; i++)
			tick(1);
		chk(16'(state), 16'(e));
	endtask

	task automatic pwr(input logic [4:0] e);
		chk(16'({lowp, pll, xcvr, core, ret}), 16'(e));
	endtask

	task automatic req(input logic sb);
		@(posedge clk_i);
		go_sb <= sb;
		go_sp <= !sb;
		@(posedge clk_i);
		go_sb <= 1'b0;
		go_sp <= 1'b0;
	endtask

	task automatic set_pads(input logic flip);
		for (int i = 0; i < 12; i++)
			pad_cfg[i] <= '{out: i[0] ^ flip, oe: i < 8, hold: i >= 6,
				pull: (i >= 8) ? lpm_pkg::PULL_UP : 2'(i % 3)};
	endtask

	task automatic t_pads();
		tick(2);
		chk(16'(gout), 16'h0AAA);
		chk(16'(goen), 16'h0F00);
		chk(16'(gpu), 16'h0F92);
		chk(16'(gpd), 16'h0024);
		chk(16'(dstr), 16'h00E4);
	endtask

	task automatic t_standby(input int s);
		req(1'b1);
		wait_st(5'h04);
		tick(2);
		pwr(5'h11);
		@(posedge clk_i);
		set_pads(1'b1);
		wk[3] <= !wk[3];
		tick(4);
		chk(16'(gout), 16'h0AAA);
		chk(16'(goen), 16'h0F00);
		chk(16'(state), 16'h0004);
		pcr_n = 0;
		@(posedge clk_i);
		wk[s] <= !wk[s];
		wait_st(5'h01);
		tick(2);
		chk(16'(pcr_n), 16'h0001);
		@(posedge clk_i);
		wk[s] <= !wk[s];
		set_pads(1'b0);
		tick(4);
		pwr(5'h0E);
	endtask

	task automatic t_cts_low();
		@(posedge clk_i);
		pol <= 1'b0;
		wk[2] <= 1'b1;
		tick(4);
		t_standby(2);
		@(posedge clk_i);
		pol <= 1'b1;
		wk[2] <= 1'b0;
		tick(4);
	endtask

	task automatic t_suspend(input int s);
		req(1'b0);
		wait_st(5'h02);
		tick(2);
		pwr(5'h17);
		pcr_n = 0;
		@(posedge clk_i);
		wk[s] <= !wk[s];
		wait_st(5'h01);
		tick(2);
		chk(16'(pcr_n), 16'(s == 0));
		@(posedge clk_i);
		wk[s] <= !wk[s];
		tick(4);
	endtask

	task automatic t_powerdown();
		@(posedge clk_i);
		vdd <= 1'b0;
		wait_st(5'h08);
		tick(2);
		pwr(5'h10);
		chk(16'(fwr), 16'h0001);
		chk(16'(goen), 16'h0F3F);
		chk(16'(gout & 12'h0C0), 16'h0080);
		pcr_n = 0;
		@(posedge clk_i);
		vdd <= 1'b1;
		wait_st(5'h01);
		tick(2);
		chk(16'(pcr_n), 16'h0001);
		chk(16'(fwr), 16'h0001);
		@(posedge clk_i);
		fw_loaded <= 1'b1;
		@(posedge clk_i);
		fw_loaded <= 1'b0;
		tick(2);
		chk(16'(fwr), 16'h0000);
	endtask

	initial begin
		set_pads(1'b0);
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		tick(3);
		pwr(5'h0E);
		chk(16'(state), 16'h0001);
		t_pads();
		for (int s = 0; s < 3; s++)
			t_standby(s);
		t_cts_low();
		for (int s = 0; s < 6; s++)
			t_suspend(s);
		t_powerdown();
		wrap_up();
	end
endmodule

/* sim/lpm_fw_model.sv */
// Purpose: Firmware side that writes the standby or suspend request register.
// Assumes: Commands from the bench arrive on clk_i.
// Notes: Each command becomes a single-cycle strobe, never a level.
`timescale 1ns/10ps
module lpm_fw_model (
	input wire logic clk_i,
	input wire logic go_sb_i,
	input wire logic go_sp_i,
	output logic standby_req_o,
	output logic suspend_req_o
);
	// register write strobe
	always_ff @(posedge clk_i) begin
		standby_req_o <= go_sb_i && !standby_req_o;
		suspend_req_o <= go_sp_i && !suspend_req_o;
	end
endmodule
